// *** link_capability_register.sv ***
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/10ps

// Function
// - speed field reads fixed 2.5 Gbps code
// - width field defaults x4, lockable override
// - invalid width code makes port run x1
// - power state support hard-wired 0x3
// - shared clock bit selects common latency
// - sleep exit latency defaults 0x2
// - reference clock removal bit defaults 0
// - surprise down report set downstream only
// - link active report set downstream only
// - bandwidth notify defaults 0, upstream zero
// - port index high byte, reserved bits zero
module link_capability_register #(
	parameter logic [7:0] PORT_INDEX = 8'h00,
	parameter logic IS_UPSTREAM = 1'b0
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [5:0] lanes_used
);

	// ----------------------------------------------------------------
	// Address decoding.
	// ----------------------------------------------------------------
	// True when a byte address falls on the word of the given register.
	function automatic logic word_hit(input logic [11:0] addr, input logic [11:0] offset);
		return addr[11:2] == offset[11:2];
	endfunction

	// ----------------------------------------------------------------
	// Write channel capture.
	// ----------------------------------------------------------------
	logic aw_held_q;
	logic [11:0] aw_addr_q;
	logic w_held_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;

	// Each channel is accepted once and held until the response is taken.
	assign s_axi_awready = !aw_held_q && !bvalid_q;
	assign s_axi_wready = !w_held_q && !bvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;

	wire do_write = aw_held_q && w_held_q && !bvalid_q;
	wire wr_cap = do_write && word_hit(aw_addr_q, link_cap_pkg::LINK_CAP_INFO_OFFSET);
	wire wr_ctrl = do_write && word_hit(aw_addr_q, link_cap_pkg::LINK_CTRL_OFFSET);
	wire wr_hit = wr_cap || wr_ctrl;

	// Capture address and data in either order, then answer.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			aw_addr_q <= 12'h000;
			w_held_q <= 1'b0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= link_cap_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (do_write) begin
				bvalid_q <= 1'b1;
				bresp_q <= wr_hit ? link_cap_pkg::RESP_OKAY : link_cap_pkg::RESP_SLVERR;
				aw_held_q <= 1'b0;
				w_held_q <= 1'b0;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Control word: shared clock and unlock bits.
	// ----------------------------------------------------------------
	logic shared_refclk_config_q;
	logic unlock_q;

	// Byte lanes of the control word are honoured individually.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			shared_refclk_config_q <= 1'b0;
			unlock_q <= 1'b0;
		end else if (wr_ctrl) begin
			if (w_strb_q[0]) begin
				shared_refclk_config_q <= w_data_q[link_cap_pkg::SHARED_REFCLK_BIT];
			end
			if (w_strb_q[3]) begin
				unlock_q <= w_data_q[link_cap_pkg::UNLOCK_BIT];
			end
		end
	end

	// ----------------------------------------------------------------
	// Lockable capability fields.
	// ----------------------------------------------------------------
	wire wr_b0 = wr_cap && w_strb_q[0];
	wire wr_b1 = wr_cap && w_strb_q[1];
	wire wr_b2 = wr_cap && w_strb_q[2];
	logic [5:0] top_lane_count;
	logic [2:0] sleep_exit_latency;
	// Stored values of the single-bit report flags.
	logic refclk_removal_ok;
	logic surprise_down_report;
	logic link_active_report;
	logic bandwidth_notify_cap;
	logic [5:0] lanes_next;
	logic [5:0] lanes_used_q;

	// Downstream ports advertise surprise down and link active reporting.
	wire port_down = !IS_UPSTREAM;

	link_cap_field #(.W(6)) lane_field (
		.aclk(aclk),
		.aresetn(aresetn),
		.reset_value(link_cap_pkg::LANES_X4),
		.write_en(wr_b0),
		.unlocked(unlock_q),
		.wdata(w_data_q[link_cap_pkg::LANES_LSB +: 6]),
		.value_q(top_lane_count)
	);

	link_cap_field #(.W(3)) sleep_field (
		.aclk(aclk),
		.aresetn(aresetn),
		.reset_value(link_cap_pkg::SLEEP_RESET),
		.write_en(wr_b1 && wr_b2),
		.unlocked(unlock_q),
		.wdata(w_data_q[link_cap_pkg::SLEEP_LSB +: 3]),
		.value_q(sleep_exit_latency)
	);

	// flags lockable writes
	// Each report flag is its own lockable bit with its own reset value.
	// refclk removal default
	link_cap_field #(.W(1)) refclk_field (
		.aclk(aclk),
		.aresetn(aresetn),
		.reset_value(link_cap_pkg::REFCLK_RESET),
		.write_en(wr_b2),
		.unlocked(unlock_q),
		.wdata(w_data_q[link_cap_pkg::REFCLK_BIT]),
		.value_q(refclk_removal_ok)
	);

	link_cap_field #(.W(1)) surprise_field (
		.aclk(aclk),
		.aresetn(aresetn),
		.reset_value(port_down),
		.write_en(wr_b2),
		.unlocked(unlock_q),
		.wdata(w_data_q[link_cap_pkg::SURPRISE_BIT]),
		.value_q(surprise_down_report)
	);

	link_cap_field #(.W(1)) active_field (
		.aclk(aclk),
		.aresetn(aresetn),
		.reset_value(port_down),
		.write_en(wr_b2),
		.unlocked(unlock_q),
		.wdata(w_data_q[link_cap_pkg::ACTIVE_BIT]),
		.value_q(link_active_report)
	);

	link_cap_field #(.W(1)) bwnotify_field (
		.aclk(aclk),
		.aresetn(aresetn),
		.reset_value(link_cap_pkg::BWNOTIFY_RESET),
		.write_en(wr_b2),
		.unlocked(unlock_q),
		.wdata(w_data_q[link_cap_pkg::BWNOTIFY_BIT]),
		.value_q(bandwidth_notify_cap)
	);

	link_cap_lanes lane_reduce (
		.lane_code(top_lane_count),
		.lanes_used(lanes_next)
	);

	// The width the port runs at is presented from a flip-flop.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lanes_used_q <= link_cap_pkg::LANES_X4;
		end else begin
			lanes_used_q <= lanes_next;
		end
	end
	assign lanes_used = lanes_used_q;

	// ----------------------------------------------------------------
	// Read value assembly.
	// ----------------------------------------------------------------
	// shared clock selects
	wire [2:0] standby_exit_latency = shared_refclk_config_q ? link_cap_pkg::STANDBY_COMMON
		: link_cap_pkg::STANDBY_SEPARATE;
	wire [3:0] flags_seen = IS_UPSTREAM ? {1'b0, 1'b0, 1'b0, refclk_removal_ok}
		: {bandwidth_notify_cap, link_active_report, surprise_down_report, refclk_removal_ok};
	wire [31:0] cap_word;
	wire [31:0] ctrl_word;

	// Each field of the capability word is placed at its own position.
	// fixed speed code
	assign cap_word[link_cap_pkg::SPEED_LSB +: 4] = link_cap_pkg::SPEED_2G5;
	assign cap_word[link_cap_pkg::LANES_LSB +: 6] = top_lane_count;
	assign cap_word[link_cap_pkg::PSTATE_LSB +: 2] = link_cap_pkg::PSTATE_L0S_L1;
	assign cap_word[link_cap_pkg::STANDBY_LSB +: 3] = standby_exit_latency;
	assign cap_word[link_cap_pkg::SLEEP_LSB +: 3] = sleep_exit_latency;
	assign cap_word[link_cap_pkg::REFCLK_BIT] = flags_seen[0];
	assign cap_word[link_cap_pkg::SURPRISE_BIT] = flags_seen[1];
	assign cap_word[link_cap_pkg::ACTIVE_BIT] = flags_seen[2];
	assign cap_word[link_cap_pkg::BWNOTIFY_BIT] = flags_seen[3];
	assign cap_word[23:22] = 2'b00;
	assign cap_word[link_cap_pkg::PORT_LSB +: 8] = PORT_INDEX;

	// Control word: only the shared clock and unlock bits are kept.
	assign ctrl_word[link_cap_pkg::UNLOCK_BIT] = unlock_q;
	assign ctrl_word[30:7] = 24'h00_0000;
	assign ctrl_word[link_cap_pkg::SHARED_REFCLK_BIT] = shared_refclk_config_q;
	assign ctrl_word[5:0] = 6'h00;

	// ----------------------------------------------------------------
	// Read channel.
	// ----------------------------------------------------------------
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;

	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	wire rd_cap = word_hit(s_axi_araddr, link_cap_pkg::LINK_CAP_INFO_OFFSET);
	wire rd_ctrl = word_hit(s_axi_araddr, link_cap_pkg::LINK_CTRL_OFFSET);
	wire [31:0] rd_mux = rd_cap ? cap_word : (rd_ctrl ? ctrl_word : 32'h0000_0000);

	// Read data is latched at the address handshake and held until taken.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= link_cap_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_mux;
			rresp_q <= (rd_cap || rd_ctrl) ? link_cap_pkg::RESP_OKAY : link_cap_pkg::RESP_SLVERR;
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

endmodule // link_capability_register

// *** link_cap_pkg.sv ***
package link_cap_pkg;

	// ----------------------------------------------------------------
	// Register map.
	// ----------------------------------------------------------------
	localparam logic [11:0] LINK_CAP_INFO_OFFSET = 12'h04c;
	localparam logic [11:0] LINK_CTRL_OFFSET = 12'h050;

	// ----------------------------------------------------------------
	// Field positions of the link capability word.
	// ----------------------------------------------------------------
	localparam int SPEED_LSB = 0;
	localparam int LANES_LSB = 4;
	localparam int PSTATE_LSB = 10;
	localparam int STANDBY_LSB = 12;
	localparam int SLEEP_LSB = 15;
	localparam int REFCLK_BIT = 18;
	localparam int SURPRISE_BIT = 19;
	localparam int ACTIVE_BIT = 20;
	localparam int BWNOTIFY_BIT = 21;
	localparam int PORT_LSB = 24;

	// Control word bits: shared reference clock and register unlock.
	localparam int SHARED_REFCLK_BIT = 6;
	localparam int UNLOCK_BIT = 31;

	// ----------------------------------------------------------------
	// Field values and reset values.
	// ----------------------------------------------------------------
	localparam logic [3:0] SPEED_2G5 = 4'h1;
	localparam logic [5:0] LANES_X1 = 6'h01;
	localparam logic [5:0] LANES_X2 = 6'h02;
	localparam logic [5:0] LANES_X4 = 6'h04;
	localparam logic [1:0] PSTATE_L0S_L1 = 2'h3;
	localparam logic [2:0] STANDBY_SEPARATE = 3'h5;
	localparam logic [2:0] STANDBY_COMMON = 3'h3;
	localparam logic [2:0] SLEEP_RESET = 3'h2;
	localparam logic REFCLK_RESET = 1'b0;
	localparam logic BWNOTIFY_RESET = 1'b0;

	// AXI response codes.
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// *** link_cap_lanes.sv ***
`timescale 1ns/10ps

// Reduces the stored width code to the width the port really uses.
module link_cap_lanes (
	input wire logic [5:0] lane_code,
	output logic [5:0] lanes_used
);

	// invalid falls to x1
	// Only x1, x2 and x4 exist on a four-lane port; anything else runs x1.
	assign lanes_used = (lane_code == link_cap_pkg::LANES_X4 || lane_code == link_cap_pkg::LANES_X2)
		? lane_code : link_cap_pkg::LANES_X1;

endmodule // link_cap_lanes

// *** link_cap_field.sv ***
`timescale 1ns/10ps

// One lockable-writable field: loads only when written while unlocked.
module link_cap_field #(
	parameter int W = 1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] reset_value,
	input wire logic write_en,
	input wire logic unlocked,
	input wire logic [W-1:0] wdata,
	output logic [W-1:0] value_q
);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			value_q <= reset_value;
		end else if (write_en && unlocked) begin
			value_q <= wdata;
		end
	end

endmodule // link_cap_field

// *** link_cap_chk.sv ***
`timescale 1ns/10ps

// Watches capability reads and the lane width the port really uses.
module link_cap_chk #(
	parameter logic [7:0] PORT_INDEX = 8'h00,
	parameter logic IS_UPSTREAM = 1'b0
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic [5:0] lanes_used
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic cap_q;
	logic cap_rd;

	// Remembers whether the read under way targets the capability word.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cap_q <= 1'b0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			cap_q <= s_axi_araddr == link_cap_pkg::LINK_CAP_INFO_OFFSET;
		end
	end
	assign cap_rd = s_axi_rvalid && cap_q;

	// Fields seen on capability reads, then the lane width the port runs at.
	chk_speed_fixed: assert property (cap_rd |-> s_axi_rdata[3:0] == 4'h1)
		else $error("speed code wrong");
	chk_pstate_wired: assert property (cap_rd |-> s_axi_rdata[11:10] == 2'h3)
		else $error("power state support wrong");
	chk_standby_code: assert property (cap_rd |-> s_axi_rdata[14:12] inside {3'h3, 3'h5})
		else $error("standby latency code wrong");
	chk_reserved_zero: assert property (cap_rd |-> s_axi_rdata[23:22] == 2'h0)
		else $error("reserved bits set");
	chk_port_index: assert property (cap_rd |-> s_axi_rdata[31:24] == PORT_INDEX)
		else $error("port index wrong");
	chk_upstream_zero: assert property (cap_rd && IS_UPSTREAM |-> s_axi_rdata[21:19] == 3'h0)
		else $error("upstream report bits set");
	chk_lanes_fallback: assert property (lanes_used inside {6'h01, 6'h02, 6'h04})
		else $error("lane width not 1, 2 or 4");
	chk_lanes_reset: assert property ($rose(aresetn) |-> lanes_used == 6'h04)
		else $error("lane width not 4 after reset");

	// Main scenarios reached.
	cover property (cap_rd);
	cover property (s_axi_rvalid && s_axi_rresp == link_cap_pkg::RESP_SLVERR);
	cover property (lanes_used == 6'h01);
endmodule // link_cap_chk

bind link_capability_register link_cap_chk #(.PORT_INDEX(PORT_INDEX), .IS_UPSTREAM(IS_UPSTREAM)) chk (
	.aclk(aclk),
	.aresetn(aresetn),
	.s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid),
	.lanes_used(lanes_used)
);

// *** tb_top.sv ***
`timescale 1ns/10ps

module tb_top;
	typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] n; logic [1:0] r; logic [5:0] l;} step_t;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000;
	logic [11:0] s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [31:0] s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic [5:0] lanes_used;
	logic [31:0] got;
	logic [31:0] got_dn;
	logic [31:0] dn_rdata;
	logic hung = 1'b0;
	int error_cnt = 0;
	int check_count = 0;
	// Upstream port at index 15 (report bits held zero), then what downstream port 3 reads.
	step_t steps[13] = '{
		'{1'h0, 12'h04c, 32'h0f01_5c41, 32'h0319_5c41, 2'h0, 6'h04},
		'{1'h1, 12'h04c, 32'hffff_ffff, 32'h0000_0000, 2'h0, 6'h04},
		'{1'h0, 12'h04c, 32'h0f01_5c41, 32'h0319_5c41, 2'h0, 6'h04},
		'{1'h1, 12'h050, 32'h8000_0040, 32'h0000_0000, 2'h0, 6'h04},
		'{1'h0, 12'h050, 32'h8000_0040, 32'h8000_0040, 2'h0, 6'h04},
		'{1'h0, 12'h04c, 32'h0f01_3c41, 32'h0319_3c41, 2'h0, 6'h04},
		'{1'h1, 12'h04c, 32'h0000_0020, 32'h0000_0000, 2'h0, 6'h02},
		'{1'h0, 12'h04c, 32'h0f00_3c21, 32'h0300_3c21, 2'h0, 6'h02},
		'{1'h1, 12'h04c, 32'hffff_ffff, 32'h0000_0000, 2'h0, 6'h01},
		'{1'h1, 12'h050, 32'h8000_0000, 32'h0000_0000, 2'h0, 6'h01},
		'{1'h0, 12'h04c, 32'h0f07_dff1, 32'h033f_dff1, 2'h0, 6'h01},
		'{1'h0, 12'h100, 32'h0000_0000, 32'h0000_0000, 2'h2, 6'h01},
		'{1'h1, 12'h100, 32'h0000_0000, 32'h0000_0000, 2'h2, 6'h01}};

	link_capability_register #(.PORT_INDEX(8'h0f), .IS_UPSTREAM(1'b1)) DUT (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.lanes_used(lanes_used)
	);

	// Downstream port on the same bus signals; it answers in step with the upstream one.
	link_capability_register #(.PORT_INDEX(8'h03), .IS_UPSTREAM(1'b0)) down_port (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(),
		.s_axi_bresp(),
		.s_axi_bvalid(),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(),
		.s_axi_rdata(dn_rdata),
		.s_axi_rresp(),
		.s_axi_rvalid(),
		.s_axi_rready(s_axi_rready),
		.lanes_used()
	);

	// Free-running 250 MHz clock.
	initial begin
		forever #2 aclk = ~aclk;
	end

	// Counts a comparison and reports a mismatch.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Prints the verdict and stops the run.
	task automatic give_verdict();
		if (error_cnt == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// One AXI write (w high) or read; each channel is released once taken.
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		logic aw, wd, ar, done;
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= w;
		s_axi_wvalid <= w;
		s_axi_bready <= w;
		s_axi_arvalid <= !w;
		s_axi_rready <= !w;
		for (n = 0; n < 64; n++) begin
			@(negedge aclk);
			aw = s_axi_awvalid && s_axi_awready;
			wd = s_axi_wvalid && s_axi_wready;
			ar = s_axi_arvalid && s_axi_arready;
			done = w ? s_axi_bvalid : s_axi_rvalid;
			got = s_axi_rdata;
			got_dn = dn_rdata;
			resp = w ? s_axi_bresp : s_axi_rresp;
			@(posedge aclk);
			if (aw) s_axi_awvalid <= 1'b0;
			if (wd) s_axi_wvalid <= 1'b0;
			if (ar) s_axi_arvalid <= 1'b0;
			if (done) break;
		end
		s_axi_bready <= 1'b0;
		s_axi_rready <= 1'b0;
		if (n == 64) begin
			error_cnt++;
			hung = 1'b1;
			$display("[FAIL] %0t no response", $time);
		end
	endtask

	// Reset, then walk the access table.
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (steps[i]) begin
			xfer(steps[i].w, steps[i].a, steps[i].d);
			if (hung) break;
			// Registered outputs of the last edge are looked at once settled.
			@(negedge aclk);
			check({30'h0, resp}, {30'h0, steps[i].r});
			if (!steps[i].w) check(got, steps[i].d);
			if (!steps[i].w) check(got_dn, steps[i].n);
			check({26'h0, lanes_used}, {26'h0, steps[i].l});
		end
		give_verdict();
	end
endmodule // tb_top
